/* File: include/qpsc_pkg.sv */
package qpsc_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int POTS    = 4;
  localparam int SLOTS   = 4;
  localparam int WIPER_W = 6;
  localparam int TAPS    = 64;
  localparam logic [WIPER_W-1:0] WIPER_MAX = 6'h3F;
  localparam logic [WIPER_W-1:0] WIPER_MIN = 6'h00;

  // ----------------------------------------------------------------
  // identification byte
  // ----------------------------------------------------------------
  // device-type code: value is arbitrary
  localparam logic [3:0] ID_TYPE_CODE = 4'h3;
  localparam logic [1:0] ID_ZERO_BITS = 2'h0;

  // ----------------------------------------------------------------
  // opcode_field encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_RD_WCR      = 4'h9;
  localparam logic [3:0] OP_WR_WCR      = 4'hA;
  localparam logic [3:0] OP_RD_SLOT     = 4'hB;
  localparam logic [3:0] OP_WR_SLOT     = 4'hC;
  localparam logic [3:0] OP_SLOT_TO_WCR = 4'hD;
  localparam logic [3:0] OP_WCR_TO_SLOT = 4'hE;
  localparam logic [3:0] OP_G_SLOT_WCR  = 4'h1;
  localparam logic [3:0] OP_G_WCR_SLOT  = 4'h8;
  localparam logic [3:0] OP_STEP        = 4'h2;
  localparam logic [3:0] OP_STATUS      = 4'h5;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  // pin order {sck, cs_n, si, hold_n, wp_n, a1, a0}; idle levels
  localparam int         SYNC_W      = 7;
  localparam logic [6:0] SYNC_RESET  = 7'h2C;
  localparam logic [5:0] SLOT_RESET  = 6'h20;
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam int         CLK_MHZ     = 100;
  localparam int         NV_WRITE_MS = 10;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_ID     = 3'b000,
    ST_INSTR  = 3'b001,
    ST_DATA   = 3'b010,
    ST_STEP   = 3'b011,
    ST_IGNORE = 3'b100
  } qpsc_state_t;

endpackage

/* File: src/qpsc_top.sv */
`timescale 1ns/1ns
// Functional notes
// - read data changes on serial clock falling edge.
// - all input bits sampled on serial clock rising edge.
// - chip select high deselects, output undriven, standby unless busy.
// - nothing accepted until a chip select falling edge after power-up.
// - hold low pauses the sequence, hold high resumes, state kept.
// - bus-select pins give two low bits of selection address.
// - address mismatch means the device ignores the rest.
// - write-protect low blocks every nonvolatile write.
// - serial output driven only while returning read data.
// - four pots, each one wiper register and four setting slots.
// - power-up loads each wiper from setting slot zero.
// - six-bit wiper decoded to exactly one of sixty-four taps.
// - never two taps on at once, also during changes.
// - first byte is type code, two zeros, bus-select bits.
// - second byte is opcode, slot select, pot select.
// - nonvolatile writes finish within 10 ms, busy flag readable.
// - step mode moves wiper per clock, up if input high.
module qpsc_top #(
  parameter int NV_WRITE_CYCLES = qpsc_pkg::NV_WRITE_CYCLES
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         sck,
  input  wire logic         cs_n,
  input  wire logic         si,
  input  wire logic         hold_n,
  input  wire logic         wp_n,
  input  wire logic [1:0]   bus_select_pins,
  output logic              so_out,
  output logic              so_oe,
  output logic              write_busy_flag,
  output logic              standby,
  output logic [255:0]      tap_enable
);

  localparam int BUSY_W = $clog2(NV_WRITE_CYCLES + 1);
  localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(NV_WRITE_CYCLES);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [6:0]            sync1;
  logic [6:0]            sync2;
  logic                  sck_prev;
  logic                  cs_prev;
  logic                  armed;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1 <= qpsc_pkg::SYNC_RESET;
      sync2 <= qpsc_pkg::SYNC_RESET;
    end else begin
      sync1 <= {sck, cs_n, si, hold_n, wp_n, bus_select_pins};
      sync2 <= sync1;
    end
  end

  logic                  sck_s;
  logic                  cs_n_s;
  logic                  si_s;
  logic                  hold_s;
  logic                  wp_s;
  logic [1:0]            addr_s;
  assign sck_s  = sync2[6];
  assign cs_n_s = sync2[5];
  assign si_s   = sync2[4];
  assign hold_s = sync2[3];
  assign wp_s   = sync2[2];
  assign addr_s = sync2[1:0];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sck_prev <= 1'b0;
      cs_prev  <= 1'b1;
    end else begin
      sck_prev <= sck_s;
      cs_prev  <= cs_n_s;
    end
  end

  logic                  cs_fall;
  logic                  cs_rise;
  logic                  active;
  logic                  sck_rise;
  logic                  sck_fall;
  assign cs_fall = cs_prev & ~cs_n_s;
  assign cs_rise = ~cs_prev & cs_n_s;
  // clock edges seen while hold is low are simply dropped
  assign active   = armed & ~cs_n_s & hold_s;
  assign sck_rise = active & sck_s & ~sck_prev;
  assign sck_fall = active & ~sck_s & sck_prev;

  // the synchroniser resets to the idle level, so a pin held low through
  // reset would look like a falling edge; require a real high first
  logic [1:0]            sync_fill;
  logic                  cs_idle_seen;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_fill    <= 2'h0;
      cs_idle_seen <= 1'b0;
    end else begin
      sync_fill <= {sync_fill[0], 1'b1};
      if (sync_fill[1] && cs_n_s) begin
        cs_idle_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (cs_fall && cs_idle_seen) begin
      armed <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // serial sequencer
  // ----------------------------------------------------------------
  qpsc_pkg::qpsc_state_t state;
  logic [7:0]            in_sr;
  logic [2:0]            bit_cnt;
  logic [3:0]            opcode;
  logic [1:0]            slot_sel;
  logic [1:0]            pot_sel;
  logic [7:0]            next_byte;
  logic                  byte_end;
  logic                  id_ok;
  logic                  instr_done;
  logic                  data_done;
  logic [3:0]            ins_op;
  logic [1:0]            ins_slot;
  logic [1:0]            ins_pot;

  assign next_byte  = {in_sr[6:0], si_s};
  assign byte_end   = sck_rise & (bit_cnt == qpsc_pkg::BIT_LAST);
  assign id_ok = (next_byte[7:4] == qpsc_pkg::ID_TYPE_CODE)
               & (next_byte[3:2] == qpsc_pkg::ID_ZERO_BITS)
               & (next_byte[1:0] == addr_s);
  assign instr_done = byte_end & (state == qpsc_pkg::ST_INSTR);
  assign data_done  = byte_end & (state == qpsc_pkg::ST_DATA);
  assign ins_op     = next_byte[7:4];
  assign ins_slot   = next_byte[3:2];
  assign ins_pot    = next_byte[1:0];

  always_ff @(posedge core_clk) begin
    if (rst || cs_n_s) begin
      state   <= qpsc_pkg::ST_ID;
      bit_cnt <= 3'h0;
      in_sr   <= 8'h00;
    end else if (sck_rise) begin
      in_sr   <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      case (state)
        qpsc_pkg::ST_ID: begin
          if (byte_end) begin
            state <= id_ok ? qpsc_pkg::ST_INSTR
                           : qpsc_pkg::ST_IGNORE;
          end
        end
        qpsc_pkg::ST_INSTR: begin
          if (byte_end) begin
            case (ins_op)
              qpsc_pkg::OP_STEP:    state <= qpsc_pkg::ST_STEP;
              qpsc_pkg::OP_RD_WCR,
              qpsc_pkg::OP_WR_WCR,
              qpsc_pkg::OP_RD_SLOT,
              qpsc_pkg::OP_WR_SLOT,
              qpsc_pkg::OP_STATUS:  state <= qpsc_pkg::ST_DATA;
              default:              state <= qpsc_pkg::ST_IGNORE;
            endcase
          end
        end
        qpsc_pkg::ST_DATA: begin
          if (byte_end) begin
            state <= qpsc_pkg::ST_IGNORE;
          end
        end
        default: state <= state;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      opcode   <= 4'h0;
      slot_sel <= 2'h0;
      pot_sel  <= 2'h0;
    end else if (instr_done) begin
      opcode   <= ins_op;
      slot_sel <= ins_slot;
      pot_sel  <= ins_pot;
    end
  end

  // ----------------------------------------------------------------
  // wiper registers and setting slots
  // ----------------------------------------------------------------
  logic [5:0]            wiper [qpsc_pkg::POTS];
  logic [5:0]            slots [qpsc_pkg::POTS][qpsc_pkg::SLOTS];
  logic                  recall;
  logic                  stepping;
  assign stepping = sck_rise & (state == qpsc_pkg::ST_STEP);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      recall <= 1'b1;
      for (int p = 0; p < qpsc_pkg::POTS; p++) begin
        wiper[p] <= qpsc_pkg::WIPER_MIN;
      end
    end else if (recall) begin
      recall <= 1'b0;
      for (int p = 0; p < qpsc_pkg::POTS; p++) begin
        wiper[p] <= slots[p][0];
      end
    end else if (instr_done && ins_op == qpsc_pkg::OP_SLOT_TO_WCR) begin
      wiper[ins_pot] <= slots[ins_pot][ins_slot];
    end else if (instr_done && ins_op == qpsc_pkg::OP_G_SLOT_WCR) begin
      for (int p = 0; p < qpsc_pkg::POTS; p++) begin
        wiper[p] <= slots[p][ins_slot];
      end
    end else if (data_done && opcode == qpsc_pkg::OP_WR_WCR) begin
      wiper[pot_sel] <= next_byte[5:0];
    end else if (stepping) begin
      // saturate at the ends rather than wrap across the array
      if (si_s && wiper[pot_sel] != qpsc_pkg::WIPER_MAX) begin
        wiper[pot_sel] <= wiper[pot_sel] + 6'h01;
      end else if (!si_s && wiper[pot_sel] != qpsc_pkg::WIPER_MIN) begin
        wiper[pot_sel] <= wiper[pot_sel] - 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile write: queued, committed at chip select rising
  // ----------------------------------------------------------------
  logic                  pend;
  logic                  pend_from_wcr;
  logic                  pend_global;
  logic [1:0]            pend_pot;
  logic [1:0]            pend_slot;
  logic [5:0]            pend_data;
  logic [BUSY_W-1:0]     busy_cnt;
  logic                  commit;

  assign write_busy_flag = (busy_cnt != '0);
  // a new write during a running one is dropped, not queued
  assign commit = cs_rise & pend & ~write_busy_flag & wp_s;

  always_ff @(posedge core_clk) begin
    if (rst || cs_rise) begin
      pend          <= 1'b0;
      pend_from_wcr <= 1'b0;
      pend_global   <= 1'b0;
      pend_pot      <= 2'h0;
      pend_slot     <= 2'h0;
      pend_data     <= 6'h00;
    end else if (instr_done && (ins_op == qpsc_pkg::OP_WCR_TO_SLOT ||
                                ins_op == qpsc_pkg::OP_G_WCR_SLOT)) begin
      pend          <= 1'b1;
      pend_from_wcr <= 1'b1;
      pend_global   <= (ins_op == qpsc_pkg::OP_G_WCR_SLOT);
      pend_pot      <= ins_pot;
      pend_slot     <= ins_slot;
    end else if (data_done && opcode == qpsc_pkg::OP_WR_SLOT) begin
      pend          <= 1'b1;
      pend_from_wcr <= 1'b0;
      pend_global   <= 1'b0;
      pend_pot      <= pot_sel;
      pend_slot     <= slot_sel;
      pend_data     <= next_byte[5:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int p = 0; p < qpsc_pkg::POTS; p++) begin
        for (int s = 0; s < qpsc_pkg::SLOTS; s++) begin
          slots[p][s] <= qpsc_pkg::SLOT_RESET;
        end
      end
    end else if (commit) begin
      for (int p = 0; p < qpsc_pkg::POTS; p++) begin
        if (pend_global || pend_pot == 2'(p)) begin
          slots[p][pend_slot] <= pend_from_wcr ? wiper[p] : pend_data;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_cnt <= '0;
    end else if (commit) begin
      busy_cnt <= BUSY_LOAD;
    end else if (write_busy_flag) begin
      busy_cnt <= busy_cnt - BUSY_W'(1);
    end
  end

  assign standby = cs_n_s & ~write_busy_flag;

  // ----------------------------------------------------------------
  // read data path
  // ----------------------------------------------------------------
  logic [7:0]            out_sr;
  logic                  reading;
  logic                  so_bit;
  logic                  so_started;

  always_ff @(posedge core_clk) begin
    if (rst || cs_n_s || data_done) begin
      out_sr     <= 8'h00;
      reading    <= 1'b0;
      so_bit     <= 1'b0;
      so_started <= 1'b0;
    end else if (instr_done) begin
      reading <= (ins_op == qpsc_pkg::OP_RD_WCR) ||
                 (ins_op == qpsc_pkg::OP_RD_SLOT) ||
                 (ins_op == qpsc_pkg::OP_STATUS);
      case (ins_op)
        qpsc_pkg::OP_RD_WCR:  out_sr <= {2'h0, wiper[ins_pot]};
        qpsc_pkg::OP_RD_SLOT: out_sr <= {2'h0, slots[ins_pot][ins_slot]};
        qpsc_pkg::OP_STATUS:  out_sr <= {7'h00, write_busy_flag};
        default:              out_sr <= 8'h00;
      endcase
    end else if (sck_fall && reading && state == qpsc_pkg::ST_DATA) begin
      so_bit     <= out_sr[7];
      out_sr     <= {out_sr[6:0], 1'b0};
      so_started <= 1'b1;
    end
  end

  assign so_out = so_bit;
  // released whenever deselected or paused so si and so can share a wire
  assign so_oe  = so_started & ~cs_n_s & hold_s;

  // ----------------------------------------------------------------
  // tap decoders, break before make
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < qpsc_pkg::POTS; gp++) begin : g_pot
      logic [5:0]  applied;
      logic [63:0] taps;
      always_ff @(posedge core_clk) begin
        if (rst) begin
          applied <= qpsc_pkg::WIPER_MIN;
          taps    <= 64'h0000000000000000;
        end else if (applied != wiper[gp]) begin
          // one all-off cycle so old and new tap never overlap
          applied <= wiper[gp];
          taps    <= 64'h0000000000000000;
        end else begin
          taps    <= 64'h0000000000000001 << applied;
        end
      end
      assign tap_enable[gp*64 +: 64] = taps;
    end
  endgenerate

endmodule

/* File: sim/qpsc_host_model.sv */
`timescale 1ns/1ns
module qpsc_host_model #(
  parameter int SCK_HI = 6,
  parameter int SCK_LO = 6
) (
  input  wire logic core_clk,
  input  wire logic so_out,
  input  wire logic so_oe,
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n
);
  // ------
  // serial master
  // ------
  // 125 ns link period rounded up to whole core cycles
  logic b;

  initial begin
    sck    = 1'b0;
    cs_n   = 1'b1;
    si     = 1'b0;
    hold_n = 1'b1;
    b      = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic pulse;
    idle(SCK_LO);
    sck <= 1'b1;
    b = so_oe ? so_out : ~b; // released line never repeats its last value
    idle(SCK_HI);
    sck <= 1'b0;
  endtask

  task automatic sel(input logic v);
    @(posedge core_clk);
    cs_n <= v;
    si   <= ~si;
    idle(3);
  endtask

  // msb first; before bit hb, pause with two ignored clocks
  task automatic bits(input logic [23:0] tx, input int n, input int hb,
                      output logic [23:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge core_clk);
      si <= tx[i] ^ (i == hb);
      if (i == hb) begin
        hold_n <= 1'b0;
        pulse;
        pulse;
        @(posedge core_clk);
        hold_n <= 1'b1;
        si     <= tx[i];
        idle(3);
      end
      pulse;
      rx = {rx[22:0], b};
    end
  endtask
endmodule

/* File: sim/qpsc_asserts.sv */
`timescale 1ns/1ns
module qpsc_checker #(
  parameter int NV_WRITE_CYCLES = 20
) (
  input wire logic         core_clk,
  input wire logic         rst,
  input wire logic         sck,
  input wire logic         cs_n,
  input wire logic         si,
  input wire logic         hold_n,
  input wire logic         wp_n,
  input wire logic [1:0]   bus_select_pins,
  input wire logic         so_out,
  input wire logic         so_oe,
  input wire logic         write_busy_flag,
  input wire logic         standby,
  input wire logic [255:0] tap_enable
);
  // ------
  // checks
  // ------
  int busy_len;

  always_ff @(posedge core_clk) begin
    if (rst || !write_busy_flag) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  tap_onehot_a: assert property (
    $onehot0(tap_enable[63:0]) && $onehot0(tap_enable[127:64]) &&
    $onehot0(tap_enable[191:128]) && $onehot0(tap_enable[255:192]))
    else $error("two taps on in one array");
  reset_recall_a: assert property ($fell(rst) |-> ##[1:5]
    (tap_enable[32] && tap_enable[96] && tap_enable[160] && tap_enable[224]))
    else $error("wipers not at slot zero after reset");
  so_release_a: assert property (cs_n [*4] |-> !so_oe)
    else $error("output driven while deselected");
  sel_active_a: assert property ((!cs_n) [*4] |-> !standby)
    else $error("standby while selected");
  busy_awake_a: assert property (
    cs_n [*4] |-> standby == !write_busy_flag)
    else $error("standby wrong while deselected");
  so_launch_a: assert property ($rose(so_oe) |-> !sck && !cs_n)
    else $error("output enabled outside a low clock phase");
  so_steady_a: assert property ((sck && so_oe) [*5]
    |-> $stable(so_out)) else $error("output moved while clock high");
  hold_quiet_a: assert property ((!hold_n) [*4] |-> !so_oe)
    else $error("output driven while paused");
  wp_block_a: assert property ((!wp_n) [*6]
    |-> !$rose(write_busy_flag)) else $error("write while protected");
  busy_bound_a: assert property (
    write_busy_flag |-> busy_len < NV_WRITE_CYCLES)
    else $error("write busy too long");
endmodule

bind qpsc_top qpsc_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk (
  .core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
  .hold_n(hold_n), .wp_n(wp_n), .bus_select_pins(bus_select_pins),
  .so_out(so_out), .so_oe(so_oe), .write_busy_flag(write_busy_flag),
  .standby(standby), .tap_enable(tap_enable));

/* File: sim/tb.sv */
`timescale 1ns/1ns
module tb;
  logic         core_clk  = 1'b0;
  logic         rst       = 1'b1;
  logic         wp_n      = 1'b1;
  logic [1:0]   pins      = 2'h2;
  logic         sck, cs_n, si, hold_n, so_out, so_oe, busy, standby;
  logic [255:0] taps;
  logic [7:0]   rx;
  int           n_fail    = 0;
  int           tests_run = 0;

  always #5 core_clk = ~core_clk;

  qpsc_top #(.NV_WRITE_CYCLES(20)) uut (
    .core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .bus_select_pins(pins),
    .so_out(so_out), .so_oe(so_oe), .write_busy_flag(busy),
    .standby(standby), .tap_enable(taps));
  qpsc_host_model host (.core_clk(core_clk), .so_out(so_out),
    .so_oe(so_oe), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n));

  // ------
  // helpers
  // ------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] id_byte;
    return {qpsc_pkg::ID_TYPE_CODE, qpsc_pkg::ID_ZERO_BITS, pins};
  endfunction

  task automatic frame(input logic [23:0] tx, input int n, input int hb);
    logic [23:0] r;
    host.sel(1'b0);
    host.bits(tx, n, hb, r);
    host.sel(1'b1);
    rx = r[7:0];
  endtask

  task automatic cmd(input logic [3:0] op, input logic [3:0] sp,
                     input logic [5:0] d);
    frame({id_byte(), op, sp, 2'b00, d}, 24, -1);
  endtask

  task automatic tap_is(input int p, input logic [5:0] w);
    check(taps[p*64 +: 64], 64'h1 << w);
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_power_up;
    repeat (6) @(posedge core_clk);
    for (int p = 0; p < qpsc_pkg::POTS; p++) begin
      tap_is(p, qpsc_pkg::SLOT_RESET);
    end
    check(standby, 1'b1);
    check(so_oe, 1'b0);
    $display("test power_up done");
  endtask

  task automatic t_write_read;
    logic [5:0] v [4] = '{6'h00, 6'h15, 6'h2A, 6'h3F};
    for (int p = 0; p < 4; p++) begin
      cmd(qpsc_pkg::OP_WR_WCR, p[3:0], v[p]);
      tap_is(p, v[p]);
    end
    for (int p = 0; p < 4; p++) begin
      cmd(qpsc_pkg::OP_RD_WCR, p[3:0], 6'h00);
      check(rx, {2'b00, v[p]});
    end
    $display("test write_read done");
  endtask

  task automatic t_bad_id;
    logic [7:0] m [3] = '{8'h01, 8'h04, 8'h80};
    foreach (m[i]) begin
      frame({id_byte() ^ m[i], qpsc_pkg::OP_WR_WCR, 12'h02B}, 24, -1);
      tap_is(0, 6'h00);
    end
    $display("test bad_id done");
  endtask

  task automatic t_step;
    frame({id_byte(), qpsc_pkg::OP_STEP, 4'h0, 3'b011}, 19, -1);
    tap_is(0, 6'h02);
    frame({id_byte(), qpsc_pkg::OP_STEP, 4'h3, 2'b10}, 18, -1);
    tap_is(3, 6'h3E);
    $display("test step done");
  endtask

  task automatic t_abort_hold;
    frame({id_byte(), qpsc_pkg::OP_WR_WCR, 4'h1, 4'h3}, 20, -1);
    tap_is(1, 6'h15);
    cmd(qpsc_pkg::OP_WR_WCR, 4'h1, 6'h07);
    tap_is(1, 6'h07);
    frame({id_byte(), qpsc_pkg::OP_WR_WCR, 4'h1, 8'h30}, 24, 10);
    tap_is(1, 6'h30);
    $display("test abort_hold done");
  endtask

  task automatic t_nv;
    cmd(qpsc_pkg::OP_WR_SLOT, 4'h9, 6'h0B);
    repeat (2) @(posedge core_clk);
    check(busy, 1'b1);
    check(standby, 1'b0);
    for (int i = 0; i < 100 && busy; i++) @(posedge core_clk);
    check(busy, 1'b0);
    wp_n <= 1'b0;
    cmd(qpsc_pkg::OP_WR_SLOT, 4'h9, 6'h01);
    repeat (2) @(posedge core_clk);
    check(busy, 1'b0);
    wp_n <= 1'b1;
    cmd(qpsc_pkg::OP_RD_SLOT, 4'h9, 6'h00);
    check(rx, 8'h0B);
    frame({id_byte(), qpsc_pkg::OP_SLOT_TO_WCR, 4'h9}, 16, -1);
    tap_is(1, 6'h0B);
    cmd(qpsc_pkg::OP_STATUS, 4'h0, 6'h00);
    check(rx, 8'h00);
    $display("test nv done");
  endtask

  task automatic t_transfer;
    logic [5:0] w [4] = '{6'h02, 6'h0B, 6'h2A, 6'h3E};
    frame({id_byte(), qpsc_pkg::OP_WCR_TO_SLOT, 4'h4}, 16, -1);
    frame({id_byte(), qpsc_pkg::OP_G_WCR_SLOT, 4'hC}, 16, -1);
    frame({id_byte(), qpsc_pkg::OP_G_SLOT_WCR, 4'h4}, 16, -1);
    for (int p = 0; p < 4; p++) begin
      tap_is(p, (p == 0) ? w[0] : qpsc_pkg::SLOT_RESET);
    end
    frame({id_byte(), qpsc_pkg::OP_G_SLOT_WCR, 4'hC}, 16, -1);
    for (int p = 0; p < 4; p++) begin
      tap_is(p, w[p]);
    end
    frame({id_byte(), 4'h0, 4'h1, 8'h15}, 24, -1);
    tap_is(1, w[1]);
    $display("test transfer done");
  endtask

  task automatic t_reset;
    logic [23:0] r;
    host.sel(1'b0);
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    host.bits({id_byte(), qpsc_pkg::OP_WR_WCR, 4'h2, 8'h11}, 24, -1, r);
    host.sel(1'b1);
    tap_is(0, qpsc_pkg::SLOT_RESET);
    tap_is(2, qpsc_pkg::SLOT_RESET);
    cmd(qpsc_pkg::OP_WR_WCR, 4'h2, 6'h11);
    tap_is(2, 6'h11);
    $display("test reset done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_power_up;
    t_write_read;
    t_bad_id;
    t_step;
    t_abort_hold;
    t_nv;
    t_transfer;
    t_reset;
    complete_run;
  end

  initial begin
    #300000;
    n_fail++;
    complete_run;
  end
endmodule
